/* File: timer_latch_consts.vh */
/*
  Addresses, field positions, reset values and counter indices for the
  count-latch and read-back logic. Assumes a 16-bit I/O address bus.
*/
`ifndef TIMER_LATCH_CONSTS_VH
`define TIMER_LATCH_CONSTS_VH

// I/O addresses
`define ADDR_DATA_CNT0    16'h0040
`define ADDR_DATA_CNT2    16'h0042
`define ADDR_DATA_CNT3    16'h0044
`define ADDR_CTRL_CNT02   16'h0043
`define ADDR_CTRL_CNT3    16'h0047

// Control word fields
`define SEL_HI_BIT        7
`define SEL_LO_BIT        6
`define FMT_HI_BIT        5
`define FMT_LO_BIT        4
`define SEL_CNT0          2'h0
`define SEL_CNT2          2'h2
`define SEL_READBACK      2'h3
`define SEL_CNT3          2'h0
`define FMT_LATCH         2'h0
`define FMT_LSB           2'h1
`define FMT_MSB           2'h2
`define FMT_LSB_MSB       2'h3

// Inspection command fields, active low capture bits
`define RB_COUNT_N_BIT    5
`define RB_STATUS_N_BIT   4
`define RB_CNT0_BIT       1
`define RB_CNT3_BIT       2
`define RB_CNT2_BIT       3

// Counter indices inside this block
`define IDX_CNT0          0
`define IDX_CNT2          1
`define IDX_CNT3          2

// Setup reset value: two-byte access, mode 0, binary
`define CFG_RESET         6'h30

`endif

/* File: hold_latch_unit.v */
/*
  Output hold latches of one counter: frozen count, captured status
  byte and the two-byte read pointer. Assumes one-cycle strobes from
  the decoder in the top module.
*/
`timescale 1ns/1ps
`include "timer_latch_consts.vh"

module hold_latch_unit
(
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Live counter state
  input  wire [15:0] live_count,
  input  wire [7:0]  status_in,
  input  wire [1:0]  rw_fmt,
  // Strobes
  input  wire        freeze_cnt,
  input  wire        freeze_sts,
  input  wire        release_all,
  input  wire        rd_stb,
  // Read data and hold state
  output wire [7:0]  rd_byte,
  output reg         count_held_q,
  output reg         status_held_q
);

  reg  [15:0] count_q;
  reg  [7:0]  status_q;
  reg         msb_next_q;
  wire [15:0] src;
  wire        take_msb;

  // Follow live count unless frozen
  assign src      = count_held_q ? count_q : live_count;
  assign take_msb = (rw_fmt == `FMT_MSB) ||
                    ((rw_fmt == `FMT_LSB_MSB) && msb_next_q);
  // Status first, then count bytes
  assign rd_byte  = status_held_q ? status_q :
                    (take_msb ? src[15:8] : src[7:0]);

  always @(posedge clk)
  begin
    if (reset)
    begin
      count_q       <= 16'h0000;
      status_q      <= 8'h00;
      count_held_q  <= 1'b0;
      status_held_q <= 1'b0;
      msb_next_q    <= 1'b0;
    end
    else if (release_all)
    begin
      // Reprogram frees the latches
      count_held_q  <= 1'b0;
      status_held_q <= 1'b0;
      msb_next_q    <= 1'b0;
    end
    else
    begin
      if (rd_stb)
      begin
        if (status_held_q)
          status_held_q <= 1'b0;
        else if ((rw_fmt == `FMT_LSB_MSB) && !msb_next_q)
          msb_next_q <= 1'b1;
        else
        begin
          msb_next_q   <= 1'b0;
          count_held_q <= 1'b0;
        end
      end
      // A pending frozen count blocks a new freeze
      if (freeze_cnt && !count_held_q)
      begin
        count_q      <= live_count;
        count_held_q <= 1'b1;
      end
      if (freeze_sts && !status_held_q)
      begin
        status_q      <= status_in;
        status_held_q <= 1'b1;
      end
    end
  end

endmodule

/* File: timer_count_latch_readback.v */
/*
  Count-latch, read-back and status capture for timer counters 0, 2
  and 3. Assumes host I/O strobes last one clock and the counting
  elements, output pins and load pulses come from outside.
*/
// Summary of operation
// - Freeze command copies live count to latches
// - Frozen count held until read or reprogram
// - Repeat freeze before read is ignored
// - Each counter freezes independently of others
// - Inspection gives count, mode, pin, null flag
// - Count bit low freezes each selected count
// - Inspected counts held until read or reprogram
// - Status bit low captures status per counter
// - Status held until data read or reprogram
// - Status bits 0-5 echo last setup; counter 3 stores only LSB-format setups, format in bits 4-5, bits 0-3 read 0
// - Status bit 7 shows output pin level
// - Setup words decode at 043H and 047H
`timescale 1ns/1ps
`include "timer_latch_consts.vh"

module timer_count_latch_readback
(
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Host I/O bus
  input  wire [15:0] io_addr,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata_q,
  // Live counter state, index 0 cnt0, 1 cnt2, 2 cnt3
  input  wire [15:0] live_count0,
  input  wire [15:0] live_count2,
  input  wire [15:0] live_count3,
  input  wire [2:0]  out_level,
  input  wire [2:0]  count_loaded,
  // Programmed setup and flags
  output reg  [17:0] setup_q,
  output reg  [2:0]  null_count_q,
  output reg  [2:0]  count_held_q,
  output reg  [2:0]  status_held_q
);

  wire        wr_ctrl02;
  wire        wr_ctrl3;
  wire [1:0]  sel;
  wire [1:0]  fmt;
  wire [2:0]  data_hit;
  wire [2:0]  rb_mask;
  reg  [2:0]  freeze_cnt;
  reg  [2:0]  freeze_sts;
  reg  [2:0]  reprogram;
  wire [2:0]  rd_stb;
  wire [2:0]  wr_data;
  wire [23:0] rd_bytes;
  wire [47:0] live_all;
  wire [2:0]  cnt_held_w;
  wire [2:0]  sts_held_w;
  reg  [7:0]  rdata_d;
  wire [2:0]  null_set;
  wire        rb_take_cnt;
  wire        rb_take_sts;

  // Address compare used for every port
  function hit;
    input [15:0] a;
    input [15:0] ref_addr;
    begin
      hit = (a == ref_addr);
    end
  endfunction

  assign wr_ctrl02 = io_wr && hit(io_addr, `ADDR_CTRL_CNT02);
  assign wr_ctrl3  = io_wr && hit(io_addr, `ADDR_CTRL_CNT3);
  assign sel = io_wdata[`SEL_HI_BIT:`SEL_LO_BIT];
  assign fmt = io_wdata[`FMT_HI_BIT:`FMT_LO_BIT];
  assign data_hit = {hit(io_addr, `ADDR_DATA_CNT3),
                     hit(io_addr, `ADDR_DATA_CNT2),
                     hit(io_addr, `ADDR_DATA_CNT0)};
  assign rd_stb  = io_rd ? data_hit : 3'h0;
  assign wr_data = io_wr ? data_hit : 3'h0;
  assign rb_mask = {io_wdata[`RB_CNT3_BIT], io_wdata[`RB_CNT2_BIT],
                    io_wdata[`RB_CNT0_BIT]};
  assign live_all = {live_count3, live_count2, live_count0};
  assign rb_take_cnt = !io_wdata[`RB_COUNT_N_BIT];
  assign rb_take_sts = !io_wdata[`RB_STATUS_N_BIT];
  assign null_set    = wr_data | reprogram;

  // Command decode
  always @*
  begin
    freeze_cnt = 3'h0;
    freeze_sts = 3'h0;
    reprogram  = 3'h0;
    if (wr_ctrl02)
    begin
      case (sel)
        `SEL_CNT0:
        begin
          if (fmt == `FMT_LATCH)
            freeze_cnt[`IDX_CNT0] = 1'b1;
          else
            reprogram[`IDX_CNT0] = 1'b1;
        end
        `SEL_CNT2:
        begin
          if (fmt == `FMT_LATCH)
            freeze_cnt[`IDX_CNT2] = 1'b1;
          else
            reprogram[`IDX_CNT2] = 1'b1;
        end
        `SEL_READBACK:
        begin
          if (rb_take_cnt)
            freeze_cnt = rb_mask;
          if (rb_take_sts)
            freeze_sts = rb_mask;
        end
        default:
        begin
          freeze_cnt = 3'h0;
        end
      endcase
    end
    else if (wr_ctrl3 && (sel == `SEL_CNT3))
    begin
      case (fmt)
        `FMT_LATCH:
          freeze_cnt[`IDX_CNT3] = 1'b1;
        `FMT_LSB:
          reprogram[`IDX_CNT3] = 1'b1;
        default:
          reprogram = 3'h0;
      endcase
    end
  end

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_cnt
      wire [7:0] status_in;
      // Pin level, null flag, last setup
      assign status_in = {out_level[i], null_count_q[i],
                          setup_q[6*i+5:6*i]};
      hold_latch_unit u_hold
      (
        .clk           (clk),
        .reset         (reset),
        .live_count    (live_all[16*i+15:16*i]),
        .status_in     (status_in),
        .rw_fmt        (setup_q[6*i+5:6*i+4]),
        .freeze_cnt    (freeze_cnt[i]),
        .freeze_sts    (freeze_sts[i]),
        .release_all   (reprogram[i]),
        .rd_stb        (rd_stb[i]),
        .rd_byte       (rd_bytes[8*i+7:8*i]),
        .count_held_q  (cnt_held_w[i]),
        .status_held_q (sts_held_w[i])
      );
    end
  endgenerate

  // Read data mux
  always @*
  begin
    case (rd_stb)
      3'h1:    rdata_d = rd_bytes[7:0];
      3'h2:    rdata_d = rd_bytes[15:8];
      3'h4:    rdata_d = rd_bytes[23:16];
      default: rdata_d = io_rdata_q;
    endcase
  end

  integer k;
  always @(posedge clk)
  begin
    if (reset)
    begin
      io_rdata_q    <= 8'h00;
      count_held_q  <= 3'h0;
      status_held_q <= 3'h0;
    end
    else
    begin
      io_rdata_q    <= rdata_d;
      count_held_q  <= cnt_held_w;
      status_held_q <= sts_held_w;
    end
  end

  // Programmed setup and null count flags
  always @(posedge clk)
  begin
    if (reset)
    begin
      setup_q      <= {3{`CFG_RESET}};
      null_count_q <= 3'h0;
    end
    else
    begin
      if (reprogram[`IDX_CNT0])
        setup_q[5:0] <= io_wdata[5:0];
      if (reprogram[`IDX_CNT2])
        setup_q[11:6] <= io_wdata[5:0];
      if (reprogram[`IDX_CNT3])
        setup_q[17:12] <= {fmt, 4'h0};
      for (k = 0; k < 3; k = k + 1)
      begin
        // New count sets, transfer clears; set wins
        if (null_set[k])
          null_count_q[k] <= 1'b1;
        else if (count_loaded[k])
          null_count_q[k] <= 1'b0;
      end
    end
  end

endmodule

/* File: latch_readback_monitor.sv */
/*
  Checker for the count-latch and read-back block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`include "timer_latch_consts.vh"

module latch_readback_monitor
(
  // Clock and reset
  input wire        clk,
  input wire        reset,
  // Host bus
  input wire [15:0] io_addr,
  input wire        io_wr,
  input wire        io_rd,
  input wire [7:0]  io_wdata,
  input wire [7:0]  io_rdata_q,
  // Counter state
  input wire [2:0]  count_loaded,
  input wire [17:0] setup_q,
  input wire [2:0]  null_count_q,
  input wire [2:0]  count_held_q,
  input wire [2:0]  status_held_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire ctl02   = io_wr && io_addr == `ADDR_CTRL_CNT02;
  wire freeze0 = ctl02 && io_wdata == 8'h00;
  wire quiet   = !io_rd && (!io_wr || freeze0);
  property p_freeze;
    (freeze0 && !count_held_q[0] && !$past(io_wr)) ##1 quiet
      |=> count_held_q[0];
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("freeze not taken");
  property p_hold;
    (count_held_q[0] && quiet && $past(quiet)) |=> count_held_q[0];
  endproperty
  a_hold: assert property (p_hold)
    else $error("frozen count lost");
  property p_sts_hold;
    (status_held_q[2] && quiet && $past(quiet)) |=> status_held_q[2];
  endproperty
  a_sts_hold: assert property (p_sts_hold)
    else $error("status lost");
  property p_sts_bits;
    (io_rd && io_addr == `ADDR_DATA_CNT3 && status_held_q[2]
      && $past(quiet)) |=> io_rdata_q[5:0] == setup_q[17:12];
  endproperty
  a_sts_bits: assert property (p_sts_bits)
    else $error("status setup bits wrong");
  property p_setup3;
    (io_wr && io_addr == `ADDR_CTRL_CNT3 && io_wdata == 8'h10)
      |=> setup_q[17:12] == 6'h10 && null_count_q[2];
  endproperty
  a_setup3: assert property (p_setup3)
    else $error("setup word not stored");
  property p_setup0;
    (ctl02 && io_wdata[7:6] == 2'b00 && io_wdata[5:4] != 2'b00)
      |=> setup_q[5:0] == $past(io_wdata[5:0]) && null_count_q[0];
  endproperty
  a_setup0: assert property (p_setup0)
    else $error("reprogram not stored");
  property p_null_clr;
    (count_loaded[2] && !io_wr) |=> !null_count_q[2];
  endproperty
  a_null_clr: assert property (p_null_clr)
    else $error("null flag not cleared");
  property p_inspect;
    (ctl02 && io_wdata == 8'hC4 && !$past(io_wr)) ##1 quiet
      |=> count_held_q[2] && status_held_q[2];
  endproperty
  a_inspect: assert property (p_inspect)
    else $error("inspection not captured");
endmodule

bind timer_count_latch_readback latch_readback_monitor
  latch_readback_monitor_i (.clk(clk), .reset(reset),
  .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
  .io_rdata_q(io_rdata_q), .count_loaded(count_loaded),
  .setup_q(setup_q), .null_count_q(null_count_q),
  .count_held_q(count_held_q), .status_held_q(status_held_q));

/* File: host_io_model.sv */
/*
  Host processor model: byte writes and reads on the timer I/O bus.
  Assumes strobes are taken on the rising clock edge.
*/
`timescale 1ns/1ps

module host_io_model
(
  // Clock and read data
  input  wire       clk,
  input  wire [7:0] io_rdata_q,
  // Host bus
  output reg [15:0] io_addr,
  output reg        io_wr,
  output reg        io_rd,
  output reg [7:0]  io_wdata
);
  initial
  begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  task wr(input [15:0] a, input [7:0] d);
  begin
    @(posedge clk);
    #1 io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #1 io_wr = 1'b0;
    io_wdata = ~d;
  end
  endtask
  // Counts frozen first, byte pairs from one caller
  task rd(input [15:0] a, output [7:0] d);
  begin
    @(posedge clk);
    #1 io_addr = a;
    io_rd = 1'b1;
    @(posedge clk);
    #1 io_rd = 1'b0;
    d = io_rdata_q;
  end
  endtask
endmodule

/* File: tb_top.sv */
/*
  Self-checking bench for the count-latch and read-back block.
  Assumes the host model drives the bus, the bench the counter inputs.
*/
`timescale 1ns/1ps
`include "timer_latch_consts.vh"

module tb_top;
  reg         clk;
  reg         reset;
  reg  [15:0] live_count0;
  reg  [15:0] live_count2;
  reg  [15:0] live_count3;
  reg  [2:0]  out_level;
  reg  [2:0]  count_loaded;
  wire [15:0] io_addr;
  wire        io_wr;
  wire        io_rd;
  wire [7:0]  io_wdata;
  wire [7:0]  io_rdata_q;
  integer     mismatches;
  integer     checks;
  reg  [7:0]  got;
  timer_count_latch_readback timer_count_latch_readback_i (.clk(clk),
    .reset(reset), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata_q(io_rdata_q),
    .live_count0(live_count0), .live_count2(live_count2),
    .live_count3(live_count3), .out_level(out_level),
    .count_loaded(count_loaded), .setup_q(), .null_count_q(),
    .count_held_q(), .status_held_q());
  host_io_model host_io_model_i (.clk(clk), .io_rdata_q(io_rdata_q),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
  always #12.5 clk = ~clk;
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task rd_chk(input [15:0] a, input [7:0] exp);
  begin
    host_io_model_i.rd(a, got);
    chk(got, exp);
  end
  endtask
  task wr(input [15:0] a, input [7:0] d);
  begin
    host_io_model_i.wr(a, d);
  end
  endtask
  task tick;
  begin
    @(posedge clk);
    #1;
  end
  endtask
  task t_freeze;
  begin
    live_count0 = 16'h1234;
    wr(`ADDR_CTRL_CNT02, 8'h00);
    live_count0 = 16'h5678;
    wr(`ADDR_CTRL_CNT02, 8'h00);
    rd_chk(`ADDR_DATA_CNT0, 8'h34);
    rd_chk(`ADDR_DATA_CNT0, 8'h12);
    rd_chk(`ADDR_DATA_CNT0, 8'h78);
    rd_chk(`ADDR_DATA_CNT0, 8'h56);
  end
  endtask
  task t_multi;
  begin
    live_count2 = 16'hABCD;
    wr(`ADDR_CTRL_CNT02, 8'h80);
    live_count0 = 16'h2468;
    wr(`ADDR_CTRL_CNT02, 8'h00);
    live_count0 = 16'h0000;
    live_count2 = 16'h0000;
    rd_chk(`ADDR_DATA_CNT0, 8'h68);
    rd_chk(`ADDR_DATA_CNT0, 8'h24);
    rd_chk(`ADDR_DATA_CNT2, 8'hCD);
    rd_chk(`ADDR_DATA_CNT2, 8'hAB);
  end
  endtask
  task t_inspect;
  begin
    out_level = 3'b100;
    live_count3 = 16'h9A5C;
    wr(`ADDR_CTRL_CNT3, 8'h10);
    wr(`ADDR_CTRL_CNT3, 8'h70);
    wr(`ADDR_CTRL_CNT02, 8'hC4);
    tick;
    tick;
    live_count3 = 16'h1111;
    out_level = 3'b000;
    rd_chk(`ADDR_DATA_CNT3, 8'hD0);
    rd_chk(`ADDR_DATA_CNT3, 8'h5C);
    rd_chk(`ADDR_DATA_CNT3, 8'h11);
    count_loaded = 3'b100;
    tick;
    count_loaded = 3'b000;
    wr(`ADDR_CTRL_CNT02, 8'hE4);
    rd_chk(`ADDR_DATA_CNT3, 8'h10);
  end
  endtask
  task t_reprog;
  begin
    rd_chk(`ADDR_CTRL_CNT02, 8'h10);
    live_count0 = 16'h0F0F;
    wr(`ADDR_CTRL_CNT02, 8'hC2);
    wr(`ADDR_CTRL_CNT02, 8'h5F);
    wr(`ADDR_CTRL_CNT02, 8'h1A);
    live_count0 = 16'h00E1;
    rd_chk(`ADDR_DATA_CNT0, 8'hE1);
    wr(`ADDR_CTRL_CNT02, 8'hE2);
    rd_chk(`ADDR_DATA_CNT0, 8'h5A);
  end
  endtask
  task t_msb;
  begin
    out_level = 3'b010;
    live_count2 = 16'hBEEF;
    wr(`ADDR_CTRL_CNT02, 8'hA0);
    count_loaded = 3'b010;
    tick;
    count_loaded = 3'b000;
    wr(`ADDR_DATA_CNT2, 8'h55);
    wr(`ADDR_CTRL_CNT3, 8'h20);
    wr(`ADDR_CTRL_CNT02, 8'hC8);
    live_count2 = 16'h7700;
    rd_chk(`ADDR_DATA_CNT2, 8'hE0);
    rd_chk(`ADDR_DATA_CNT2, 8'hBE);
    rd_chk(`ADDR_DATA_CNT2, 8'h77);
    wr(`ADDR_CTRL_CNT02, 8'hE4);
    rd_chk(`ADDR_DATA_CNT3, 8'h10);
  end
  endtask
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    live_count0 = 16'h0000;
    live_count2 = 16'h0000;
    live_count3 = 16'h0000;
    out_level = 3'b000;
    count_loaded = 3'b000;
    mismatches = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    t_freeze;
    t_multi;
    t_inspect;
    t_reprog;
    t_msb;
    end_sim;
  end
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    end_sim;
  end
endmodule
